// File: design/aur_cfg.svh
// Address map, field positions, counts and response codes of the asynchronous receiver.
// Assumes byte addresses on a 32-bit AXI4-Lite data bus, one register per word.
`ifndef AUR_CFG_SVH
`define AUR_CFG_SVH
// ************************************************************
// Register byte addresses
// ************************************************************
`define AUR_ADDR_RSC 8'h00
`define AUR_ADDR_BAUD 8'h04
`define AUR_ADDR_DIVL 8'h08
`define AUR_ADDR_DIVH 8'h0c
`define AUR_ADDR_DATA 8'h10
`define AUR_ADDR_ISTAT 8'h14
`define AUR_ADDR_IMASK 8'h18
// ************************************************************
// Field positions
// ************************************************************
`define AUR_RSC_SERIAL_PORT_ENABLE 7
`define AUR_RSC_RX9 6
`define AUR_RSC_SYNC 5
`define AUR_RSC_CONTINUOUS_RX_ENABLE 4
`define AUR_RSC_FERR 2
`define AUR_RSC_OERR 1
`define AUR_RSC_RX9D 0
`define AUR_BAUD_INV 5
`define AUR_BAUD_WIDE 3
`define AUR_BAUD_HS 2
`define AUR_IRQ_RXC 0
`define AUR_IRQ_FERR 1
`define AUR_IRQ_OERR 2
// ************************************************************
// Counts and answers
// ************************************************************
`define AUR_OVERSAMPLE 16
`define AUR_VOTE_FIRST 4'h7
`define AUR_VOTE_LAST 4'h9
`define AUR_BITS_8 4'h7
`define AUR_BITS_9 4'h8
`define AUR_RESP_OKAY 2'h0
`define AUR_RESP_SLVERR 2'h2
`endif

// File: design/aur_pkg.sv
// Types shared by the asynchronous receiver files.
// Assumes aur_cfg.svh supplies the numeric constants.
package aur_pkg;
  // Port and frame control bits.
  typedef struct packed {
    logic serial_port_enable;
    logic rx9;
    logic sync;
    logic continuous_rx_enable;
  } aur_ctrl_t;
  // Baud generator and line settings.
  typedef struct packed {
    logic inv;
    logic wide;
    logic hs;
    logic [15:0] div;
  } aur_baud_t;
  // Frame assembly states, Gray coded along start, data, stop.
  typedef enum logic [1:0] {
    AUR_ST_START = 2'b00,
    AUR_ST_DATA = 2'b01,
    AUR_ST_STOP = 2'b11
  } aur_state_t;
  // Received word held for software.
  typedef struct packed {
    logic full;
    logic ferr;
    logic oerr;
    logic [8:0] data;
  } aur_buf_t;
endpackage

// File: design/aur_rx_recovery.sv
// Data recovery shifter: finds the start edge and resolves each bit from x16 samples.
// Assumes tick pulses at sixteen times the baud rate and line is already polarity corrected.
`timescale 1ns/1ns
`include "aur_cfg.svh"
module aur_rx_recovery #(
  parameter int OVS = `AUR_OVERSAMPLE
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Sampling control.
  input wire logic tick,
  input wire logic rearm,
  input wire logic line,
  // Resolved bits.
  output logic bit_stb,
  output logic bit_val
);
  localparam int SW = $clog2(OVS);
  logic run_q, run_d;
  logic [SW-1:0] sub_q, sub_d;
  logic [1:0] vote_q, vote_d;
  logic stb_d, val_q, val_d;

  // Next state: hunt for a low level, then count sixteen samples per bit and vote on the middle three.
  always_comb begin
    run_d = run_q;
    sub_d = sub_q;
    vote_d = vote_q;
    stb_d = 1'b0;
    val_d = val_q;
    if (rearm) begin
      run_d = 1'b0;
    end else if (tick) begin
      if (!run_q) begin
        if (!line) begin
          run_d = 1'b1;
          sub_d = '0;
          vote_d = 2'h0;
        end
      end else begin
        if (sub_q >= SW'(`AUR_VOTE_FIRST) && sub_q <= SW'(`AUR_VOTE_LAST) && line) begin // R1
          vote_d = vote_q + 2'h1;
        end
        sub_d = SW'(sub_q + 1'b1);
        if (sub_q == SW'(OVS - 1)) begin
          stb_d = 1'b1;
          val_d = (vote_d >= 2'h2); // R1
          vote_d = 2'h0;
        end
      end
    end
  end

  // State registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_q <= 1'b0;
      sub_q <= '0;
      vote_q <= 2'h0;
      bit_stb <= 1'b0;
      val_q <= 1'b1;
    end else begin
      run_q <= run_d;
      sub_q <= sub_d;
      vote_q <= vote_d;
      bit_stb <= stb_d;
      val_q <= val_d;
    end
  end

  assign bit_val = val_q;

  // A resolved bit never appears while hunting for a start edge.
  a_strobe_in_run: assert property (@(posedge aclk) disable iff (!aresetn) // R1
    bit_stb |-> $past(run_q)) else $error("bit strobe without running frame");
endmodule

// File: design/aur_rx_top.sv
// Asynchronous serial receiver with baud divisor, AXI4-Lite registers and one interrupt.
// Assumes serial_input_pin is synchronous to aclk and idles high after polarity correction.
//
// Function
// R1: Recover each bit by sampling the line at sixteen times the baud rate.
// R2: Shift the frame register once per resolved bit period.
// R3: Invert the incoming line before recovery when the polarity bit is set.
// R4: Port runs asynchronously only with sync mode clear and port enabled.
// R5: Software loads divisors and speed bits before enabling reception.
// R6: Receive nine data bits when ninth-bit enable is set, else eight.
// R7: Accept frames only while continuous receive enable is set.
// R8: Set the complete flag per frame; interrupt only when enabled.
// R9: Show ninth data bit and error flags in the status register.
// R10: Give the low eight data bits in the data buffer register.
// R11: Clearing continuous receive enable clears latched reception errors.
// R12: Software sets global and peripheral interrupt enables in its controller.
// R13: Low speed, divisor 207, 4 MHz clock gives 0.300 K baud.
// R14: High speed, divisor 207, 4 MHz clock gives 1.202 K baud.
// R15: Baud is clock over 64(n+1) low speed, 16(n+1) high speed.
// R16: Frame is low start, LSB-first data, high stop; low stop is framing error.
`timescale 1ns/1ns
`include "aur_cfg.svh"
module aur_rx_top #(
  parameter int ADDR_W = 8
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write channels.
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read channels.
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Serial line and interrupt.
  input wire logic serial_input_pin,
  output logic irq
);
  // ************************************************************
  // Declarations
  // ************************************************************
  aur_pkg::aur_ctrl_t ctrl_q, ctrl_d;
  aur_pkg::aur_baud_t baud_q, baud_d;
  aur_pkg::aur_buf_t buf_q, buf_d;
  aur_pkg::aur_state_t state_q, state_d;
  logic [2:0] stat_q, stat_d, mask_q, mask_d, stat_set, stat_clr;
  logic [17:0] cnt_q, cnt_d, reload;
  logic [8:0] shift_q, shift_d;
  logic [3:0] nbit_q, nbit_d;
  logic port_on, rx_on, tick, line, bit_stb, bit_val, rearm, frame_done;
  logic [ADDR_W-1:0] aw_q, aw_d;
  logic [7:0] wd_q, wd_d;
  logic have_aw_q, have_aw_d, have_w_q, have_w_d, wen_q, wen_d;
  logic bvalid_d, rvalid_d, do_write, do_read;
  logic [1:0] bresp_d, rresp_d;
  logic [31:0] rdata_d;

  // ************************************************************
  // Baud generator and line
  // ************************************************************
  // The port is live only in asynchronous mode with the port enabled.
  assign port_on = ctrl_q.serial_port_enable && !ctrl_q.sync; // R4
  assign rx_on = port_on && ctrl_q.continuous_rx_enable; // R7
  assign line = serial_input_pin ^ baud_q.inv; // R3

  // Sample tick every n+1 clocks at high speed or wide divisor, else every 4(n+1).
  always_comb begin
    if (baud_q.hs || baud_q.wide) begin
      reload = {2'b00, (baud_q.wide ? baud_q.div : {8'h00, baud_q.div[7:0]})}; // R15
    end else begin
      reload = {8'h00, baud_q.div[7:0], 2'b11}; // R15
    end
    tick = port_on && (cnt_q == 18'h00000);
    cnt_d = cnt_q;
    if (!port_on || tick) begin
      cnt_d = reload; // R13 R14
    end else begin
      cnt_d = cnt_q - 18'h00001;
    end
  end

  aur_rx_recovery #(
    .OVS(`AUR_OVERSAMPLE)
  ) u_recovery (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick),
    .rearm(rearm),
    .line(line),
    .bit_stb(bit_stb),
    .bit_val(bit_val)
  );

  // ************************************************************
  // Frame assembly
  // ************************************************************
  // Check the start bit, shift data LSB first, then judge the stop bit.
  always_comb begin
    state_d = state_q;
    shift_d = shift_q;
    nbit_d = nbit_q;
    rearm = !rx_on;
    frame_done = 1'b0;
    if (!rx_on) begin
      state_d = aur_pkg::AUR_ST_START;
    end else if (bit_stb) begin
      case (state_q)
        aur_pkg::AUR_ST_START: begin
          if (!bit_val) begin // R16
            state_d = aur_pkg::AUR_ST_DATA;
            nbit_d = 4'h0;
          end else begin
            rearm = 1'b1;
          end
        end
        aur_pkg::AUR_ST_DATA: begin
          shift_d = {bit_val, shift_q[8:1]}; // R2
          nbit_d = nbit_q + 4'h1;
          if (nbit_q == (ctrl_q.rx9 ? `AUR_BITS_9 : `AUR_BITS_8)) begin // R6
            state_d = aur_pkg::AUR_ST_STOP;
          end
        end
        aur_pkg::AUR_ST_STOP: begin
          frame_done = 1'b1;
          rearm = 1'b1;
          state_d = aur_pkg::AUR_ST_START;
        end
        default: begin
          rearm = 1'b1;
          state_d = aur_pkg::AUR_ST_START;
        end
      endcase
    end
  end

  // ************************************************************
  // Receive buffer, status and interrupt
  // ************************************************************
  // Load a finished frame unless the previous one is unread; errors clear with reception.
  always_comb begin
    buf_d = buf_q;
    stat_set = 3'h0;
    if (do_read && araddr == ADDR_W'(`AUR_ADDR_DATA)) begin
      buf_d.full = 1'b0;
    end
    if (frame_done) begin
      stat_set[`AUR_IRQ_RXC] = 1'b1; // R8
      if (buf_q.full && !(do_read && araddr == ADDR_W'(`AUR_ADDR_DATA))) begin // A read in the same cycle frees it.
        buf_d.oerr = 1'b1;
        stat_set[`AUR_IRQ_OERR] = 1'b1;
      end else begin
        buf_d.full = 1'b1;
        buf_d.ferr = !bit_val; // R16
        buf_d.data = ctrl_q.rx9 ? shift_q : {1'b0, shift_q[8:1]}; // R10
        stat_set[`AUR_IRQ_FERR] = !bit_val;
      end
    end
    if (!ctrl_q.continuous_rx_enable) begin
      buf_d.oerr = 1'b0; // R11
      buf_d.ferr = 1'b0; // R11
    end
    stat_clr = (wen_q && aw_q == ADDR_W'(`AUR_ADDR_ISTAT)) ? wd_q[2:0] : 3'h0;
    stat_d = (stat_q & ~stat_clr) | stat_set;
  end

  assign irq = |(stat_q & mask_q); // R8

  // ************************************************************
  // AXI4-Lite slave
  // ************************************************************
  // Address and data are latched in either order; the write lands once both are held.
  assign awready = !have_aw_q && !bvalid;
  assign wready = !have_w_q && !bvalid;
  assign arready = !rvalid;
  assign do_write = have_aw_q && have_w_q && !bvalid;
  assign do_read = arvalid && arready;

  always_comb begin
    aw_d = aw_q;
    wd_d = wd_q;
    have_aw_d = have_aw_q;
    have_w_d = have_w_q;
    bvalid_d = bvalid && !bready;
    bresp_d = bresp;
    wen_d = 1'b0;
    ctrl_d = ctrl_q;
    baud_d = baud_q;
    mask_d = mask_q;
    if (awvalid && awready) begin
      aw_d = awaddr;
      have_aw_d = 1'b1;
    end
    if (wvalid && wready) begin
      wd_d = wstrb[0] ? wdata[7:0] : 8'h00;
      have_w_d = 1'b1;
    end
    if (do_write) begin
      have_aw_d = 1'b0;
      have_w_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = `AUR_RESP_OKAY;
      wen_d = 1'b1;
      case (aw_q)
        ADDR_W'(`AUR_ADDR_RSC): begin
          ctrl_d = {wd_q[`AUR_RSC_SERIAL_PORT_ENABLE], wd_q[`AUR_RSC_RX9], wd_q[`AUR_RSC_SYNC], wd_q[`AUR_RSC_CONTINUOUS_RX_ENABLE]};
        end
        ADDR_W'(`AUR_ADDR_BAUD): begin
          baud_d.inv = wd_q[`AUR_BAUD_INV];
          baud_d.wide = wd_q[`AUR_BAUD_WIDE];
          baud_d.hs = wd_q[`AUR_BAUD_HS];
        end
        ADDR_W'(`AUR_ADDR_DIVL): baud_d.div[7:0] = wd_q;
        ADDR_W'(`AUR_ADDR_DIVH): baud_d.div[15:8] = wd_q;
        ADDR_W'(`AUR_ADDR_IMASK): mask_d = wd_q[2:0];
        ADDR_W'(`AUR_ADDR_ISTAT), ADDR_W'(`AUR_ADDR_DATA): bresp_d = `AUR_RESP_OKAY;
        default: bresp_d = `AUR_RESP_SLVERR;
      endcase
    end
  end

  // Read data are captured at the address handshake; unmapped reads answer zero with an error.
  always_comb begin
    rvalid_d = rvalid && !rready;
    rdata_d = rdata;
    rresp_d = rresp;
    if (do_read) begin
      rvalid_d = 1'b1;
      rresp_d = `AUR_RESP_OKAY;
      rdata_d = 32'h00000000;
      case (araddr)
        ADDR_W'(`AUR_ADDR_RSC): begin
          rdata_d[`AUR_RSC_SERIAL_PORT_ENABLE] = ctrl_q.serial_port_enable;
          rdata_d[`AUR_RSC_RX9] = ctrl_q.rx9;
          rdata_d[`AUR_RSC_SYNC] = ctrl_q.sync;
          rdata_d[`AUR_RSC_CONTINUOUS_RX_ENABLE] = ctrl_q.continuous_rx_enable;
          rdata_d[`AUR_RSC_FERR] = buf_q.ferr; // R9
          rdata_d[`AUR_RSC_OERR] = buf_q.oerr; // R9
          rdata_d[`AUR_RSC_RX9D] = buf_q.data[8]; // R9
        end
        ADDR_W'(`AUR_ADDR_BAUD): begin
          rdata_d[`AUR_BAUD_INV] = baud_q.inv;
          rdata_d[`AUR_BAUD_WIDE] = baud_q.wide;
          rdata_d[`AUR_BAUD_HS] = baud_q.hs;
        end
        ADDR_W'(`AUR_ADDR_DIVL): rdata_d[7:0] = baud_q.div[7:0];
        ADDR_W'(`AUR_ADDR_DIVH): rdata_d[7:0] = baud_q.div[15:8];
        ADDR_W'(`AUR_ADDR_DATA): rdata_d[7:0] = buf_q.data[7:0]; // R10
        ADDR_W'(`AUR_ADDR_ISTAT): rdata_d[2:0] = stat_q;
        ADDR_W'(`AUR_ADDR_IMASK): rdata_d[2:0] = mask_q;
        default: rresp_d = `AUR_RESP_SLVERR;
      endcase
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  // All state of the block except the recovery shifter, cleared by the synchronous reset.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= '0;
      baud_q <= '0;
      buf_q <= '0;
      state_q <= aur_pkg::AUR_ST_START;
      stat_q <= 3'h0;
      mask_q <= 3'h0;
      cnt_q <= 18'h00000;
      shift_q <= 9'h000;
      nbit_q <= 4'h0;
      aw_q <= '0;
      wd_q <= 8'h00;
      have_aw_q <= 1'b0;
      have_w_q <= 1'b0;
      wen_q <= 1'b0;
      bvalid <= 1'b0;
      bresp <= 2'h0;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= 2'h0;
    end else begin
      ctrl_q <= ctrl_d;
      baud_q <= baud_d;
      buf_q <= buf_d;
      state_q <= state_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      cnt_q <= cnt_d;
      shift_q <= shift_d;
      nbit_q <= nbit_d;
      aw_q <= aw_d;
      wd_q <= wd_d;
      have_aw_q <= have_aw_d;
      have_w_q <= have_w_d;
      wen_q <= wen_d;
      bvalid <= bvalid_d;
      bresp <= bresp_d;
      rvalid <= rvalid_d;
      rdata <= rdata_d;
      rresp <= rresp_d;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  a_tick_low_speed: assert property (@(posedge aclk) disable iff (!aresetn || !port_on) // R15
    (tick && !baud_q.hs && !baud_q.wide && baud_q.div[7:0] == 8'h00 && !do_write)
    |-> ##1 (!tick)[*3] ##1 tick) else $error("low speed tick spacing wrong");
  a_tick_high_speed: assert property (@(posedge aclk) disable iff (!aresetn || !port_on) // R14
    (tick && baud_q.hs && !baud_q.wide && baud_q.div[7:0] == 8'h03 && !do_write)
    |-> ##1 (!tick)[*3] ##1 tick) else $error("high speed tick spacing wrong");
  a_port_gated: assert property (@(posedge aclk) disable iff (!aresetn) // R4
    !port_on |-> !tick) else $error("tick while port disabled");
  a_no_frame_off: assert property (@(posedge aclk) disable iff (!aresetn) // R7
    !rx_on |-> !frame_done && state_d == aur_pkg::AUR_ST_START) else $error("frame while reception off");
  a_data_length: assert property (@(posedge aclk) disable iff (!aresetn) // R6
    (state_q == aur_pkg::AUR_ST_DATA && bit_stb && rx_on && nbit_q == (ctrl_q.rx9 ? 4'h8 : 4'h7))
    |=> state_q == aur_pkg::AUR_ST_STOP) else $error("wrong data bit count");
  a_shift_hold: assert property (@(posedge aclk) disable iff (!aresetn) // R2
    !bit_stb |=> $stable(shift_q)) else $error("shift without resolved bit");
  a_flag_on_done: assert property (@(posedge aclk) disable iff (!aresetn) // R8
    frame_done |=> stat_q[`AUR_IRQ_RXC]) else $error("complete flag not set");
  a_irq_masked: assert property (@(posedge aclk) disable iff (!aresetn) // R8
    (mask_q == 3'h0) |-> !irq) else $error("interrupt while masked");
  a_frame_error: assert property (@(posedge aclk) disable iff (!aresetn) // R16
    (frame_done && !buf_q.full && ctrl_q.continuous_rx_enable) |=> buf_q.full && buf_q.ferr == !$past(bit_val))
    else $error("framing error not captured");
  a_error_clear: assert property (@(posedge aclk) disable iff (!aresetn) // R11
    !ctrl_q.continuous_rx_enable |=> !buf_q.oerr && !buf_q.ferr) else $error("errors kept after disable");
endmodule

// File: verif/aur_serial_src.sv
// Remote asynchronous transmitter model that drives the receiver's serial line.
// Assumes send is called just after a rising edge of aclk.
`timescale 1ns/1ns
module aur_serial_src #(
  parameter int BIT_CLKS = 64
) (
  // Clock.
  input wire logic aclk,
  // Line control and line.
  input wire logic inv,
  output logic line
);
  // ************************************************************
  // Line driver
  // ************************************************************
  // The line idles at the mark level until the first frame.
  logic raw = 1'b1;
  // An inverting level shifter flips the whole line, idle level included.
  assign line = raw ^ inv;
  // Sends start, nb data bits LSB first, stop, then one idle bit time.
  task automatic send(input logic [8:0] d, input int nb, input logic stop);
    int i;
    for (i = 0; i < nb + 3; i++) begin
      if (i == 0) begin
        raw <= 1'b0;
      end else if (i <= nb) begin
        raw <= d[i-1];
      end else if (i == nb + 1) begin
        raw <= stop;
      end else begin
        raw <= 1'b1;
      end
      repeat (BIT_CLKS) @(posedge aclk);
    end
  endtask
endmodule

// File: verif/test_aur_rx_top.sv
// Self-checking bench for the asynchronous receiver, registers reached over AXI4-Lite.
// Assumes a 50 MHz clock and a tick of four clocks, so one bit lasts 64 clocks.
`timescale 1ns/1ns
`include "aur_cfg.svh"
module test_aur_rx_top;
  // ************************************************************
  // Signals and instances
  // ************************************************************
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, serial_input_pin, irq, line_inv;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  int n_fail, num_checks, k;
  int cyc = 0;
  logic [7:0] off_rsc [3] = '{8'h80, 8'h10, 8'hb0};
  logic [7:0] cfg_baud [3] = '{8'h00, 8'h08, 8'h04};
  logic [7:0] cfg_div [3] = '{8'h00, 8'h03, 8'h03};
  logic [7:0] cfg_dat [3] = '{8'ha5, 8'h3c, 8'hc3};
  aur_rx_top uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .serial_input_pin(serial_input_pin), .irq(irq));
  aur_serial_src #(.BIT_CLKS(64)) src (.aclk(aclk), .inv(line_inv), .line(serial_input_pin));
  // ************************************************************
  // Tasks
  // ************************************************************
  // Compares a register word or a response code.
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Compares the interrupt line.
  task automatic chk1(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One write; address and data offered together, each released when taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = `AUR_RESP_OKAY);
    logic ha, hw;
    ha = 1'b0;
    hw = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (1) begin
      @(posedge aclk);
      if (ha && hw && bvalid === 1'b1) break;
      if (!ha && awready === 1'b1) begin
        ha = 1'b1;
        awvalid <= 1'b0;
      end
      if (!hw && wready === 1'b1) begin
        hw = 1'b1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b0;
    @(posedge aclk); // Lets the late status clear land and keeps ready apart from the next call.
    chk32({30'h0, bresp}, {30'h0, er});
  endtask
  // One read, compared with the expected word and response.
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er = `AUR_RESP_OKAY);
    logic ta;
    ta = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (1) begin
      @(posedge aclk);
      if (ta && rvalid === 1'b1) break;
      if (arready === 1'b1) begin
        ta = 1'b1;
        arvalid <= 1'b0;
      end
    end
    rready <= 1'b0;
    @(posedge aclk); // Read data and response stand until the next read.
    chk32(rdata, exp);
    chk32({30'h0, rresp}, {30'h0, er});
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ************************************************************
  // Clock, timeout and tests
  // ************************************************************
  // Free-running 50 MHz clock.
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  // A hang counts as a mismatch and goes to the verdict.
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      give_verdict();
    end
  end
  // Test sequence.
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, line_inv} = 7'h0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hf;
    n_fail = 0;
    num_checks = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset values of the map; the word past the map is refused.
    for (k = 0; k < 8; k++) begin
      rd(8'(k * 4), 32'h0, (k == 7) ? `AUR_RESP_SLVERR : `AUR_RESP_OKAY);
    end
    wr(8'h1c, 32'hff, `AUR_RESP_SLVERR);
    wr(`AUR_ADDR_DIVH, 32'h5a);
    rd(`AUR_ADDR_DIVH, 32'h5a);
    wstrb <= 4'he;
    wr(`AUR_ADDR_DIVH, 32'hff);
    rd(`AUR_ADDR_DIVH, 32'h0);
    wstrb <= 4'hf;
    chk1(irq, 1'b0);
    $display("test reset_map finished");
    // Frames are ignored unless the port is enabled, async and receiving.
    wr(`AUR_ADDR_DIVL, 32'h03);
    wr(`AUR_ADDR_BAUD, 32'h04);
    for (k = 0; k < 3; k++) begin
      wr(`AUR_ADDR_RSC, {24'h0, off_rsc[k]});
      src.send(9'h0f0, 8, 1'b1);
      rd(`AUR_ADDR_ISTAT, 32'h0);
    end
    $display("test gating finished");
    // Three divisor settings that all give 64 clocks a bit.
    wr(`AUR_ADDR_RSC, 32'h90);
    for (k = 0; k < 3; k++) begin
      wr(`AUR_ADDR_BAUD, {24'h0, cfg_baud[k]});
      wr(`AUR_ADDR_DIVL, {24'h0, cfg_div[k]});
      src.send({1'b0, cfg_dat[k]}, 8, 1'b1);
      rd(`AUR_ADDR_ISTAT, 32'h1);
      chk1(irq, 1'b0);
      wr(`AUR_ADDR_IMASK, 32'h1);
      chk1(irq, 1'b1);
      rd(`AUR_ADDR_RSC, 32'h90);
      rd(`AUR_ADDR_DATA, {24'h0, cfg_dat[k]});
      wr(`AUR_ADDR_ISTAT, 32'h1);
      chk1(irq, 1'b0);
      wr(`AUR_ADDR_IMASK, 32'h0);
    end
    $display("test baud_modes finished");
    // Nine data bits; the top bit shows in the status register.
    wr(`AUR_ADDR_RSC, 32'hd0);
    src.send(9'h15a, 9, 1'b1);
    rd(`AUR_ADDR_RSC, 32'hd1);
    rd(`AUR_ADDR_DATA, 32'h5a);
    wr(`AUR_ADDR_ISTAT, 32'h1);
    wr(`AUR_ADDR_RSC, 32'h90);
    $display("test nine_bits finished");
    // A second frame into a full buffer is an overrun; disabling clears it.
    src.send(9'h011, 8, 1'b1);
    src.send(9'h022, 8, 1'b1);
    rd(`AUR_ADDR_RSC, 32'h92);
    rd(`AUR_ADDR_ISTAT, 32'h5);
    wr(`AUR_ADDR_IMASK, 32'h4);
    chk1(irq, 1'b1);
    rd(`AUR_ADDR_DATA, 32'h11);
    wr(`AUR_ADDR_RSC, 32'h80);
    rd(`AUR_ADDR_RSC, 32'h80);
    wr(`AUR_ADDR_ISTAT, 32'h7);
    $display("test overrun finished");
    // A low stop bit is a framing error; disabling clears it.
    wr(`AUR_ADDR_RSC, 32'h90);
    src.send(9'h055, 8, 1'b0);
    rd(`AUR_ADDR_RSC, 32'h94);
    rd(`AUR_ADDR_ISTAT, 32'h3);
    chk1(irq, 1'b0);
    rd(`AUR_ADDR_DATA, 32'h55);
    wr(`AUR_ADDR_RSC, 32'h80);
    rd(`AUR_ADDR_RSC, 32'h80);
    wr(`AUR_ADDR_ISTAT, 32'h7);
    $display("test framing finished");
    // An inverted line is corrected before recovery.
    wr(`AUR_ADDR_BAUD, 32'h24);
    line_inv <= 1'b1;
    wr(`AUR_ADDR_RSC, 32'h90);
    src.send(9'h081, 8, 1'b1);
    rd(`AUR_ADDR_ISTAT, 32'h1);
    rd(`AUR_ADDR_DATA, 32'h81);
    rd(`AUR_ADDR_BAUD, 32'h24);
    $display("test invert finished");
    give_verdict();
  end
endmodule
